/* src/tpsu_pkg.sv */
/*
 Constants, types and helpers of the tone programming and status unit.
 Assumes a 25 MHz system clock and one 16-bit register port.
*/
package tpsu_pkg;
   // Clock and times
   localparam int CLK_HZ = 25_000_000;
   localparam int PROG_DONE_US = 150;
   localparam int PROG_DONE_CYC = PROG_DONE_US * (CLK_HZ / 1_000_000);
   localparam int MODE_SETTLE_US = 150;
   localparam int MODE_SETTLE_CYC = MODE_SETTLE_US * (CLK_HZ / 1_000_000);
   localparam int TICK_HZ = 9600;
   localparam logic [11:0] TICK_DIV = 12'(CLK_HZ / TICK_HZ - 1);
   localparam logic [3:0] PROG_LAT = 4'h4;
   // Register addresses
   localparam logic [7:0] ADDR_GRESET = 8'h01;
   localparam logic [7:0] ADDR_GCTRL = 8'hE0;
   localparam logic [7:0] ADDR_TXMODE = 8'hE1;
   localparam logic [7:0] ADDR_RXMODE = 8'hE2;
   localparam logic [7:0] ADDR_STATUS = 8'hE6;
   localparam logic [7:0] ADDR_PROG = 8'hE8;
   // General control bits
   localparam int GC_IRQ_EN = 6;
   localparam int GC_RESET = 7;
   localparam int GC_POWER = 8;
   // Status bits
   localparam int ST_RING = 14;
   localparam int ST_PF = 13;
   localparam int ST_EVT_LO = 5;
   // Receive mode field
   localparam logic [2:0] RXM_OFF = 3'h0;
   localparam logic [2:0] RXM_DTMF = 3'h1;
   localparam logic [2:0] RXM_TONES = 3'h2;
   localparam logic [2:0] RXM_PROG = 3'h3;
   localparam logic [2:0] RXM_FSK = 3'h4;
   localparam int RXM_DESCR = 3;
   // Programming words
   localparam logic [15:0] HDR_TX = 16'h8000;
   localparam logic [15:0] HDR_RX = 16'h8001;
   localparam int TX_WORDS = 16;
   localparam int RX_WORDS = 26;
   localparam int RX_PER_DET = 13;
   localparam int COEF_PER_SEC = 5;
   localparam int IDX_NCYC = 10;
   localparam int IDX_MIN = 11;
   localparam int IDX_MAX = 12;
   localparam logic [14:0] COEF_UNITY = 15'h2000;
   localparam int DEF_NCYC = 8;
   localparam int DEF_TOL_PCT = 5;
   localparam int FREQ_LO_HZ = 2130;
   localparam int FREQ_HI_HZ = 2750;
   localparam int FREQ_MUL_MILLI = 3414;

   typedef enum logic [0:0] {PS_IDLE = 1'b0, PS_BUSY = 1'b1} tpsu_pstate_t;
   typedef enum logic [1:0] {SEQ_NONE = 2'b00, SEQ_TX = 2'b01, SEQ_RX = 2'b10} tpsu_seq_t;

   // Same-clock events from the modem datapaths
   typedef struct packed {
      logic tx_ready;
      logic tx_underflow;
      logic rx_ready;
      logic rx_overflow;
      logic energy;
      logic cp_energy;
      logic s1;
      logic frame_err;
      logic parity_even;
      logic tone1;
      logic tone2;
      logic dtmf_valid;
      logic [2:0] quality;
   } tpsu_evt_t;

   // One transmit tone pair
   typedef struct packed {
      logic [13:0] f1;
      logic [13:0] l1;
      logic [13:0] f2;
      logic [13:0] l2;
      logic silent1;
      logic silent2;
   } tpsu_tone_t;

   // Frequency word from hertz, rounded
   function automatic logic [13:0] hz_word(input int hz);
      hz_word = 14'((hz * FREQ_MUL_MILLI + 500) / 1000);
   endfunction

   // Power-up transmit table
   function automatic logic [13:0] tx_default(input int idx, input logic [13:0] lvl);
      tx_default = 14'h0;
      if (idx == TX_WORDS - 4) tx_default = hz_word(FREQ_LO_HZ);
      if (idx == TX_WORDS - 2) tx_default = hz_word(FREQ_HI_HZ);
      if (idx == TX_WORDS - 3 || idx == TX_WORDS - 1) tx_default = lvl;
   endfunction

   // Power-up receive table: pass-through filters, timing windows
   function automatic logic [14:0] rx_default(input int idx);
      int k;
      int f;
      k = idx % RX_PER_DET;
      f = (idx < RX_PER_DET) ? FREQ_LO_HZ : FREQ_HI_HZ;
      rx_default = 15'h0;
      if (k == 2 || k == 7) rx_default = COEF_UNITY;
      if (k == IDX_NCYC) rx_default = 15'(DEF_NCYC);
      if (k == IDX_MIN) rx_default = 15'(TICK_HZ * DEF_NCYC * 100 / (f * (100 + DEF_TOL_PCT)));
      if (k == IDX_MAX) rx_default = 15'(TICK_HZ * DEF_NCYC * 100 / (f * (100 - DEF_TOL_PCT)));
   endfunction

   // Key code from row and column index
   function automatic logic [3:0] dtmf_code(input logic [1:0] row, input logic [1:0] col);
      if (col == 2'h3) dtmf_code = (row == 2'h3) ? 4'h0 : 4'(4'hD + row);
      else if (row == 2'h3) dtmf_code = (col == 2'h0) ? 4'hB : (col == 2'h1) ? 4'hA : 4'hC;
      else dtmf_code = 4'(row * 3 + col + 1);
   endfunction

   // Word slot of one filter coefficient
   function automatic logic [4:0] coef_index(input logic det, input logic sec, input logic [2:0] term);
      coef_index = 5'(det * RX_PER_DET + sec * COEF_PER_SEC + term);
   endfunction
endpackage

/* src/tpsu_freq_det.sv */
/*
 Frequency measurement for one programmed receive tone.
 Assumes edge_in pulses once per input cycle and tick_in at 9.6 kHz.
*/
`timescale 1ns/10ps
`default_nettype none
module tpsu_freq_det (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic ce_in,
   // Timing and signal
   input wire logic tick_in,
   input wire logic edge_in,
   input wire logic restart_in,
   // Programmed limits
   input wire logic [14:0] ncyc_in,
   input wire logic [14:0] min_in,
   input wire logic [14:0] max_in,
   // Result
   output logic ok_out
);
   logic [14:0] cyc_q; // Cycles seen in this window
   logic [14:0] time_q; // Ticks in this window
   logic ok_q;
   wire last_cyc = edge_in && (15'(cyc_q + 15'h1) >= ncyc_in);
   wire in_range = (time_q >= min_in) && (time_q <= max_in);
   assign ok_out = ok_q;

   // Count ticks across ncycles, then judge the window
   always_ff @(posedge clk_sys_in) begin
      if (srst_in || (ce_in && restart_in)) begin
         cyc_q <= 15'h0;
         time_q <= 15'h0;
         ok_q <= 1'b0;
      end else if (ce_in) begin
         if (last_cyc) begin
            ok_q <= in_range;
            cyc_q <= 15'h0;
            time_q <= 15'h0;
         end else begin
            if (edge_in) cyc_q <= 15'(cyc_q + 15'h1);
            if (tick_in && time_q != 15'h7FFF) time_q <= 15'(time_q + 15'h1);
         end
      end
   end

   chk_det_verdict: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && !restart_in && last_cyc) |=> ok_q == $past(in_range))
      else $error("detector verdict wrong");
endmodule
`default_nettype wire

/* src/tpsu_top.sv */
/*
 Status, interrupt and tone programming register bank.
 Assumes the serial bus is already decoded into one-cycle read and write
 strobes on this clock; event inputs come from same-clock datapaths.
*/
`timescale 1ns/10ps
`default_nettype none
module tpsu_top #(
   parameter int CONT_RUN = 32,
   parameter logic [13:0] TD_LEVEL = 14'h1000
) (
   // Clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic ce_in,
   // Register port
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic [7:0] bus_addr_in,
   input wire logic [15:0] bus_wdata_in,
   output logic [15:0] bus_rdata_out,
   output logic bus_rvalid_out,
   // Pins
   input wire logic ring_detect_in,
   output logic interrupt_out_low_out,
   // Datapath status
   input wire tpsu_pkg::tpsu_evt_t evt_in,
   input wire logic descr_bit_in,
   input wire logic descr_strobe_in,
   input wire logic fsk_bit_in,
   input wire logic fsk_strobe_in,
   input wire logic [1:0] dtmf_row_in,
   input wire logic [1:0] dtmf_col_in,
   input wire logic [1:0] det_edge_in,
   // Tone tables
   input wire logic [1:0] tone_sel_in,
   output tpsu_pkg::tpsu_tone_t tone_out,
   input wire logic [4:0] coef_sel_in,
   output logic [14:0] coef_out
);
   import tpsu_pkg::*;

   logic [8:0] gc_q; // General control
   logic [15:0] txm_q; // Transmit mode
   logic [15:0] rxm_q; // Receive mode
   logic [14:0] stat_q; // Status bits 14-0
   logic irq_q; // Interrupt bit
   logic pf_q; // Programming done flag
   logic ring_s1_q; // Ring synchroniser
   logic ring_s2_q;
   logic fsk_q; // Demodulator sample
   logic [3:0] dcode_q; // Last key code
   logic [5:0] run_q; // Run of equal bits
   logic run_bit_q; // Bit of that run
   logic [11:0] tick_cnt_q; // 9.6 kHz divider
   logic tick_q;
   tpsu_pstate_t ps_q; // Programming state
   tpsu_seq_t seq_q; // Sequence kind
   logic [4:0] idx_q; // Next word slot
   logic [15:0] word_q; // Word being stored
   logic [3:0] lat_q; // Store latency
   logic [13:0] tx_ram [TX_WORDS]; // Transmit pairs
   logic [14:0] rx_shadow [RX_WORDS]; // Loaded receive values
   logic [14:0] rx_active [RX_WORDS]; // Values in use
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic irq_pin_q;
   tpsu_tone_t tone_q;
   logic [14:0] coef_q;
   wire [1:0] det_ok; // Detector verdicts, one driver per bit

   // Port decode
   wire wr_gc = bus_wr_in && bus_addr_in == ADDR_GCTRL;
   wire wr_txm = bus_wr_in && bus_addr_in == ADDR_TXMODE;
   wire wr_rxm = bus_wr_in && bus_addr_in == ADDR_RXMODE;
   wire wr_prog = bus_wr_in && bus_addr_in == ADDR_PROG;
   wire wr_grst = bus_wr_in && bus_addr_in == ADDR_GRESET;
   wire rd_stat = bus_rd_in && bus_addr_in == ADDR_STATUS;
   // Next general control value, so the pin follows the enable at once
   wire [8:0] gc_d = wr_gc ? bus_wdata_in[8:0] : gc_q;
   wire clr_stat = gc_q[GC_RESET] || wr_grst;
   // Interrupt bit clear sources
   wire gc_wr_clr = wr_gc && (bus_wdata_in[GC_RESET] || bus_wdata_in[GC_POWER]);
   wire irq_clr = rd_stat || wr_grst || gc_wr_clr;
   // Table reload on powersave entry or reset bit
   wire pwr_down = wr_gc && gc_q[GC_POWER] && !bus_wdata_in[GC_POWER];
   wire ram_init = wr_grst || (wr_gc && bus_wdata_in[GC_RESET]) || pwr_down;
   // Entry into programmed tone mode
   wire prog_entry = wr_rxm && bus_wdata_in[2:0] == RXM_PROG && rxm_q[2:0] != RXM_PROG;
   wire [2:0] rxm = rxm_q[2:0];
   wire modem = rxm >= RXM_FSK;
   wire fsk = rxm == RXM_FSK;
   wire descr = rxm_q[RXM_DESCR];

   wire cont1 = run_bit_q && run_q >= 6'(CONT_RUN);
   wire cont0 = !run_bit_q && run_q >= 6'(CONT_RUN);
   wire [1:0] cont_code = cont1 ? (descr ? 2'b11 : 2'b01) : (cont0 ? 2'b10 : 2'b00);
   wire [2:0] low3 = fsk ? {2'b00, fsk_q} : evt_in.quality;
   wire t1 = (rxm == RXM_PROG) ? det_ok[0] : evt_in.tone1;
   wire t2 = (rxm == RXM_PROG) ? det_ok[1] : evt_in.tone2;
   wire [12:0] low_modem = {evt_in.tx_ready, evt_in.tx_underflow, evt_in.energy, evt_in.s1,
      cont_code, evt_in.rx_ready, evt_in.rx_overflow, evt_in.frame_err, evt_in.parity_even, low3};
   wire [12:0] low_tone = {evt_in.tx_ready, evt_in.tx_underflow, evt_in.cp_energy | (t1 & t2),
      2'b00, t2, t1, evt_in.dtmf_valid, 1'b0, dcode_q};
   wire [12:0] low_d = clr_stat ? 13'h0 : modem ? low_modem : (rxm == RXM_OFF) ? 13'h0 : low_tone;
   wire [14:0] stat_d = {ring_s2_q, pf_q && !clr_stat, low_d};
   wire [9:0] mask_vec = {gc_q[5], gc_q[4], gc_q[3], gc_q[3], gc_q[2],
      gc_q[1], gc_q[1], gc_q[1], gc_q[0], gc_q[0]};
   wire [9:0] rise = stat_d[14:5] & ~stat_q[14:5] & mask_vec;
   wire irq_d = (|rise) || (irq_q && !irq_clr);
   wire store_now = ps_q == PS_BUSY && lat_q == 4'h0;

   assign bus_rdata_out = rdata_q;
   assign bus_rvalid_out = rvalid_q;
   assign interrupt_out_low_out = irq_pin_q;
   assign tone_out = tone_q;
   assign coef_out = coef_q;

   // Ring pin synchroniser
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ring_s1_q <= 1'b0;
         ring_s2_q <= 1'b0;
      end else if (ce_in) begin
         ring_s1_q <= ring_detect_in;
         ring_s2_q <= ring_s1_q;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         gc_q <= 9'h0;
         txm_q <= 16'h0;
         rxm_q <= 16'h0;
      end else if (ce_in) begin
         gc_q <= gc_d;
         if (wr_txm) txm_q <= bus_wdata_in;
         if (wr_rxm) rxm_q <= bus_wdata_in;
      end
   end

   // Status, interrupt bit and pin
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         stat_q <= 15'h0;
         irq_q <= 1'b0;
         irq_pin_q <= 1'b1;
      end else if (ce_in) begin
         stat_q <= stat_d;
         irq_q <= irq_d;
         // pin low on bit and enable
         irq_pin_q <= !(irq_d && gc_d[GC_IRQ_EN]);
      end
   end

   // Demodulator sample, key code, run detector, tick
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         fsk_q <= 1'b0;
         dcode_q <= 4'h0;
         run_q <= 6'h0;
         run_bit_q <= 1'b0;
         tick_cnt_q <= 12'h0;
         tick_q <= 1'b0;
      end else if (ce_in) begin
         if (fsk_strobe_in) fsk_q <= fsk_bit_in;
         if (evt_in.dtmf_valid) dcode_q <= dtmf_code(dtmf_row_in, dtmf_col_in);
         if (descr_strobe_in) begin
            run_bit_q <= descr_bit_in;
            if (descr_bit_in != run_bit_q) run_q <= 6'h1;
            else if (run_q != 6'h3F) run_q <= 6'(run_q + 6'h1);
         end
         tick_q <= tick_cnt_q == TICK_DIV;
         tick_cnt_q <= (tick_cnt_q == TICK_DIV) ? 12'h0 : 12'(tick_cnt_q + 12'h1);
      end
   end

   // Programming handshake
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ps_q <= PS_IDLE;
         pf_q <= 1'b1;
         seq_q <= SEQ_NONE;
         idx_q <= 5'h0;
         word_q <= 16'h0;
         lat_q <= 4'h0;
      end else if (ce_in) begin
         if (ram_init) begin
            ps_q <= PS_IDLE;
            seq_q <= SEQ_NONE;
            pf_q <= 1'b1;
         end else if (wr_prog) begin
            pf_q <= 1'b0;
            ps_q <= PS_BUSY;
            word_q <= bus_wdata_in;
            lat_q <= PROG_LAT;
         end else if (store_now) begin
            pf_q <= 1'b1;
            ps_q <= PS_IDLE;
            if (word_q == HDR_TX) begin
               seq_q <= SEQ_TX;
               idx_q <= 5'h0;
            end else if (word_q == HDR_RX) begin
               seq_q <= SEQ_RX;
               idx_q <= 5'h0;
            end else if (seq_q != SEQ_NONE) begin
               idx_q <= 5'(idx_q + 5'h1);
            end
         end else if (ps_q == PS_BUSY) begin
            lat_q <= 4'(lat_q - 4'h1);
         end
      end
   end

   // Tone tables
   always_ff @(posedge clk_sys_in) begin
      if (srst_in || (ce_in && ram_init)) begin
         for (int i = 0; i < TX_WORDS; i++) tx_ram[i] <= tx_default(i, TD_LEVEL);
         for (int i = 0; i < RX_WORDS; i++) rx_shadow[i] <= rx_default(i);
         for (int i = 0; i < RX_WORDS; i++) rx_active[i] <= rx_default(i);
      end else if (ce_in) begin
         if (store_now && seq_q == SEQ_TX && !word_q[15] && idx_q < 5'(TX_WORDS))
            tx_ram[idx_q[3:0]] <= word_q[13:0];
         if (store_now && seq_q == SEQ_RX && !word_q[15] && idx_q < 5'(RX_WORDS))
            rx_shadow[idx_q] <= word_q[14:0];
         if (prog_entry)
            for (int i = 0; i < RX_WORDS; i++) rx_active[i] <= rx_shadow[i];
      end
   end

   // Read port and table views
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rdata_q <= 16'h0;
         rvalid_q <= 1'b0;
         tone_q <= '0;
         coef_q <= 15'h0;
      end else if (ce_in) begin
         rvalid_q <= bus_rd_in;
         if (bus_rd_in) rdata_q <= rd_stat ? {irq_q, stat_q} : 16'h0;
         tone_q.f1 <= tx_ram[{tone_sel_in, 2'h0}];
         tone_q.l1 <= tx_ram[{tone_sel_in, 2'h1}];
         tone_q.f2 <= tx_ram[{tone_sel_in, 2'h2}];
         tone_q.l2 <= tx_ram[{tone_sel_in, 2'h3}];
         tone_q.silent1 <= tx_ram[{tone_sel_in, 2'h0}] == 14'h0 && tx_ram[{tone_sel_in, 2'h1}] == 14'h0;
         tone_q.silent2 <= tx_ram[{tone_sel_in, 2'h2}] == 14'h0 && tx_ram[{tone_sel_in, 2'h3}] == 14'h0;
         coef_q <= (coef_sel_in < 5'(RX_WORDS)) ? rx_active[coef_sel_in] : 15'h0;
      end
   end

   // Two frequency detectors
   for (genvar d = 0; d < 2; d++) begin : g_det
      tpsu_freq_det u_det (
         .clk_sys_in(clk_sys_in),
         .srst_in(srst_in),
         .ce_in(ce_in),
         .tick_in(tick_q),
         .edge_in(det_edge_in[d]),
         .restart_in(prog_entry),
         .ncyc_in(rx_active[coef_index(1'(d), 1'b0, 3'h0) + 5'(IDX_NCYC)]),
         .min_in(rx_active[coef_index(1'(d), 1'b0, 3'h0) + 5'(IDX_MIN)]),
         .max_in(rx_active[coef_index(1'(d), 1'b0, 3'h0) + 5'(IDX_MAX)]),
         .ok_out(det_ok[d])
      );
   end

   chk_irq_pin_level: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      interrupt_out_low_out == !(irq_q && gc_q[GC_IRQ_EN]))
      else $error("interrupt pin disagrees with bit");
   chk_irq_cause: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      $rose(irq_q) |-> |(stat_q[14:5] & ~$past(stat_q[14:5]) & $past(mask_vec)))
      else $error("interrupt without masked event");
   chk_read_clears: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && rd_stat && rise == 10'h0) |=> !irq_q)
      else $error("status read left interrupt set");
   chk_pf_write_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && wr_prog && !ram_init) |=> !pf_q)
      else $error("flag not cleared by write");
   chk_pf_return: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && wr_prog && !ram_init) ##1 (ce_in && !bus_wr_in)[*6] |=> pf_q)
      else $error("flag not restored after store");
   chk_fsk_low_bits: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && fsk && !clr_stat) |=> stat_q[2:0] == {2'b00, $past(fsk_q)})
      else $error("fsk status bits wrong");
   chk_reset_bit: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && gc_q[GC_RESET]) |=> stat_q[ST_PF:0] == 14'h0)
      else $error("reset bit left status set");
   chk_ring_live: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in [*3]) |=> stat_q[ST_RING] == $past(ring_detect_in, 3))
      else $error("ring bit not tracking pin");
   chk_mode_settle: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && wr_rxm && bus_wdata_in[2:0] == RXM_OFF) ##1 ce_in [*2] |-> stat_q[12:0] == 13'h0)
      else $error("status not settled after mode change");
endmodule
`default_nettype wire

/* test/tpsu_host.sv */
/*
 Host model: register port master of the status and tone programming bank.
 Assumes one-cycle strobes taken on the rising edge, driven at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tpsu_host (
   // Clock and answer
   input wire logic clk_sys_in,
   input wire logic [15:0] bus_rdata_in,
   input wire logic bus_rvalid_in,
   // Request
   output logic bus_wr_out,
   output logic bus_rd_out,
   output logic [7:0] bus_addr_out,
   output logic [15:0] bus_wdata_out
);
   import tpsu_pkg::*;
   // Idle port at time zero
   initial begin
      {bus_wr_out, bus_rd_out, bus_addr_out, bus_wdata_out} = '0;
   end
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys_in);
      {bus_wr_out, bus_addr_out, bus_wdata_out} = {1'b1, a, d};
      @(negedge clk_sys_in);
      bus_wr_out = 1'b0;
   endtask
   // Read; data taken while the valid pulse stands
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      int n;
      @(negedge clk_sys_in);
      {bus_rd_out, bus_addr_out} = {1'b1, a};
      @(negedge clk_sys_in);
      bus_rd_out = 1'b0;
      for (n = 0; n < 4 && bus_rvalid_in !== 1'b1; n++) @(negedge clk_sys_in);
      // No answer: hand back unknowns so the compare fails
      d = (bus_rvalid_in === 1'b1) ? bus_rdata_in : 16'hXXXX;
   endtask
   // write only once the flag is back
   task automatic wr_safe(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] s;
      int n;
      s = '0;
      for (n = 0; n < 2000 && s[ST_PF] !== 1'b1; n++) rd(ADDR_STATUS, s);
      // Flag never came back: count it and end the run
      if (s[ST_PF] !== 1'b1) begin
         tpsu_top_test.miscompares++;
         tpsu_top_test.finish_test();
      end
      wr(a, d);
   endtask
endmodule
`default_nettype wire

/* test/tpsu_top_test.sv */
/*
 Self-checking bench of the status and tone programming bank.
 Assumes the host model in tpsu_host.sv drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module tpsu_top_test;
   import tpsu_pkg::*;
   logic clk_sys_in, srst_in, ce, ring, dbit, dstb, fbit, fstb, wr, rd, rvalid, irq_n;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, s;
   logic [1:0] row, col, tsel, dedge;
   logic [4:0] csel;
   logic [14:0] coef;
   tpsu_evt_t evt;
   tpsu_tone_t tone;
   logic [15:0] w [26];
   int miscompares = 0, checked = 0, seed = 32'hCF364B26, i, k;
   // Compare and count
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Frequency word from hertz
   function automatic logic [15:0] fword(int hz);
      return 16'((hz * 3414 + 500) / 1000);
   endfunction
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic st;
      host_u.rd(ADDR_STATUS, s);
   endtask
   // All four pairs against the word table
   task automatic tones_chk;
      int b;
      for (int p = 0; p < 4; p++) begin
         b = 4 * p;
         tsel = 2'(p);
         cyc(3);
         check("tone", tone, {w[b][13:0], w[b+1][13:0], w[b+2][13:0], w[b+3][13:0],
            w[b] == 0 && w[b+1] == 0, w[b+2] == 0 && w[b+3] == 0});
      end
   endtask
   task automatic coef_chk(int n, logic [14:0] exp);
      csel = 5'(n);
      cyc(3);
      check("coef", coef, exp);
   endtask
   // Power-up tables
   task automatic dflt_chk;
      for (k = 0; k < 16; k++) w[k] = 16'h0;
      {w[12], w[13], w[14], w[15]} = {fword(2130), 16'h1000, fword(2750), 16'h1000};
      tones_chk;
      for (k = 0; k < 26; k++) if (k % 13 < 10) coef_chk(k, (k % 13 == 2 || k % 13 == 7) ? 15'h2000 : 15'h0);
   endtask
   tpsu_top #(.CONT_RUN(8)) dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce),
      .bus_wr_in(wr), .bus_rd_in(rd), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
      .bus_rvalid_out(rvalid), .ring_detect_in(ring), .interrupt_out_low_out(irq_n), .evt_in(evt),
      .descr_bit_in(dbit), .descr_strobe_in(dstb), .fsk_bit_in(fbit), .fsk_strobe_in(fstb),
      .dtmf_row_in(row), .dtmf_col_in(col), .det_edge_in(dedge), .tone_sel_in(tsel), .tone_out(tone),
      .coef_sel_in(csel), .coef_out(coef));
   tpsu_host host_u (.clk_sys_in(clk_sys_in), .bus_rdata_in(rdata), .bus_rvalid_in(rvalid),
      .bus_wr_out(wr), .bus_rd_out(rd), .bus_addr_out(addr), .bus_wdata_out(wdata));
   // 25 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // Hang guard
   initial begin
      #2000000;
      miscompares++;
      finish_test;
   end
   initial begin
      {srst_in, ce, ring, dbit, dstb, fbit, fstb, row, col, tsel, csel, dedge, evt} = {2'b11, 33'h0};
      cyc(5);
      srst_in = 1'b0;
      check("pin", irq_n, 1);
      st;
      check("flag", s[ST_PF], 1);
      dflt_chk;
      // Header write then an at-once status read sees the flag down
      host_u.wr(ADDR_PROG, HDR_TX);
      st;
      check("busy", s[ST_PF], 0);
      for (i = 0; i < 16; i++) begin
         w[i] = (i == 6 || i == 7) ? 16'h0 : 16'($random(seed)) & 16'h3FFF;
         host_u.wr_safe(ADDR_PROG, w[i]);
      end
      tones_chk;
      // Receive table, made active by entering programmed tone mode
      host_u.wr_safe(ADDR_PROG, HDR_RX);
      for (i = 0; i < 26; i++) begin
         w[i] = (i == 10) ? 16'h1 : (i == 11) ? 16'h2 : (i == 12) ? 16'h3 : 16'($random(seed)) & 16'h7FFF;
         host_u.wr_safe(ADDR_PROG, w[i]);
      end
      host_u.wr_safe(ADDR_RXMODE, {13'h0, RXM_PROG});
      for (i = 0; i < 26; i++) coef_chk(i, w[i][14:0]);
      // Reprogram while running: old value stays until the mode is entered again
      host_u.wr_safe(ADDR_PROG, HDR_RX);
      host_u.wr_safe(ADDR_PROG, 16'h1234);
      coef_chk(0, w[0][14:0]);
      // Off mode drops the tone status bits
      evt.tx_ready = 1'b1;
      host_u.wr_safe(ADDR_RXMODE, {13'h0, RXM_OFF});
      st;
      check("off", s[12:0], 0);
      evt.tx_ready = 1'b0;
      host_u.wr_safe(ADDR_RXMODE, {13'h0, RXM_PROG});
      coef_chk(0, 15'h1234);
      // One cycle per window: 2.5 ticks accepted, a short cycle refused
      for (i = 0; i < 4; i++) begin
         cyc(i < 3 ? 6509 : 499);
         dedge = 2'b01;
         cyc(1);
         dedge = 2'b00;
         st;
         check("detect", s[6], i < 3);
      end
      // Powersave entry restores the tables
      host_u.wr(ADDR_GCTRL, 16'h0100);
      host_u.wr(ADDR_GCTRL, 16'h0000);
      dflt_chk;
      // Ring with reset bit, pin enable and ring mask
      host_u.wr(ADDR_GCTRL, 16'h00E0);
      ce = 1'b0;
      ring = 1'b1;
      cyc(6);
      check("freeze", irq_n, 1);
      ce = 1'b1;
      cyc(6);
      check("pin", irq_n, 0);
      st;
      check("status", s, 16'hC000);
      st;
      check("clear", {s[15], irq_n}, 2'b01);
      // Ring mask bit clear: nothing raised
      ring = 1'b0;
      host_u.wr(ADDR_GCTRL, 16'h0040);
      ring = 1'b1;
      cyc(6);
      st;
      check("mask", {s[15], irq_n}, 2'b01);
      // Pin disabled: bit set, pin stays high
      ring = 1'b0;
      host_u.wr(ADDR_GCTRL, 16'h0020);
      ring = 1'b1;
      cyc(6);
      check("pin off", irq_n, 1);
      st;
      check("bit", s[15], 1);
      // Every key code
      host_u.wr(ADDR_GCTRL, 16'h0100);
      host_u.wr_safe(ADDR_RXMODE, {13'h0, RXM_DTMF});
      evt.dtmf_valid = 1'b1;
      for (i = 0; i < 16; i++) begin
         {row, col} = 4'(i);
         cyc(2);
         st;
         check("key", s[3:0], 4'(64'h0CABF987E654D321 >> 4 * i));
      end
      // Demodulator bit with quality forced out
      host_u.wr_safe(ADDR_RXMODE, {13'h0, RXM_FSK});
      evt.quality = 3'h7;
      for (i = 0; i < 8; i++) begin
         fbit = 1'($random(seed));
         fstb = 1'b1;
         cyc(1);
         fstb = 1'b0;
         st;
         check("fsk", s[2:0], {2'b00, fbit});
      end
      // Runs of ones, descrambler off then on, then zeros
      for (i = 0; i < 3; i++) begin
         dbit = i != 2;
         host_u.wr_safe(ADDR_RXMODE, 16'(5 + 8 * (i % 2)));
         repeat (10) begin
            dstb = 1'b1;
            cyc(1);
            dstb = 1'b0;
            cyc(1);
         end
         st;
         check("run", s[8:7], 2'(6'h2D >> 2 * i));
      end
      finish_test;
   end
endmodule
`default_nettype wire
